// File: lhbp_pkg.sv
// package: constants and types for the lcd host bus port
package lhbp_pkg;
    localparam int ADDR_W      = 17;
    localparam int DATA_W      = 16;
    localparam int BYTE_W      = 8;
    localparam int STRAP_W     = 3;
    localparam int ARB_CYCLES  = 2;
    localparam logic [2:0] STRAP_GENERIC = 3'h7;
    localparam logic [2:0] STRAP_STROBE  = 3'h3;
    localparam logic       ENDIAN_LITTLE = 1'h0;
    localparam logic       ENDIAN_BIG    = 1'h1;

    typedef enum logic [1:0] {
        LHBP_MODE_NONE    = 2'h0,
        LHBP_MODE_GENERIC = 2'h1,
        LHBP_MODE_STROBE  = 2'h2
    } lhbp_mode_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [1:0]        byte_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lhbp_req_t;
endpackage : lhbp_pkg

// File: lhbp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module lhbp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    // inactive value of the pins is high, so reset to all ones
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule : lhbp_sync

// File: lhbp_port.sv
// host bus port: generic and strobe modes, wait, strap latch
`timescale 1ns/10ps
// Function
// - host side runs on host bus clock
// - data path sixteen bits wide
// - generic mode takes byte address, data
// - generic write enables per byte, active low
// - generic read enables per byte, active low
// - wait low until data ready or taken
// - arbitrate against refresh, hold wait meanwhile
// - strobe mode word address from bits 1..16
// - strobe mode byte enables bit0, high write
// - strobe mode direction low write, high read
// - bus start strobe marks valid address
// - latch straps and strobe at reset release
// - endian strap low little, high big
module lhbp_port (
    input  wire logic                          i_clk,
    input  wire logic                          i_reset,
    input  wire logic                          i_chip_select_n,
    input  wire logic [lhbp_pkg::ADDR_W-1:0]   i_host_addr_in,
    input  wire logic [lhbp_pkg::DATA_W-1:0]   i_host_data_bus,
    output logic      [lhbp_pkg::DATA_W-1:0]   o_host_data_bus,
    output logic                               o_host_data_bus_oe,
    input  wire logic                          i_low_byte_write_n,
    input  wire logic                          i_high_byte_write_n,
    input  wire logic                          i_low_byte_read_n,
    input  wire logic                          i_read_dir,
    input  wire logic                          i_bus_start_strobe_n,
    input  wire logic [lhbp_pkg::STRAP_W-1:0]  i_bus_mode_straps,
    input  wire logic                          i_endian_strap,
    output logic                               o_wait_n,
    output lhbp_pkg::lhbp_req_t                o_req,
    input  wire logic                          i_refresh_busy,
    input  wire logic                          i_core_done,
    input  wire logic [lhbp_pkg::DATA_W-1:0]   i_core_rdata,
    output lhbp_pkg::lhbp_mode_t               o_mode,
    output logic                               o_big_endian
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; i_clk is the host bus clock
    localparam int NS = 7 + lhbp_pkg::STRAP_W;
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] pin_s;
    logic          cs_n_s;
    logic          lwe_n_s;
    logic          hwe_n_s;
    logic          lrd_n_s;
    logic          dir_s;
    logic          bs_n_s;
    logic          endian_s;
    logic [lhbp_pkg::STRAP_W-1:0] straps_s;

    assign pin_raw = {i_chip_select_n, i_low_byte_write_n, i_high_byte_write_n,
                      i_low_byte_read_n, i_read_dir, i_bus_start_strobe_n,
                      i_endian_strap, i_bus_mode_straps};

    lhbp_sync #(.W(NS)) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (pin_raw),
        .o_sync  (pin_s)
    );

    assign {cs_n_s, lwe_n_s, hwe_n_s, lrd_n_s, dir_s, bs_n_s, endian_s, straps_s} = pin_s;

    ////////////////////////////////////////////////////////////////////////
    // address and data take the same two flops as the controls, so a cycle
    // decodes against the address that arrived with its enables
    logic [lhbp_pkg::ADDR_W-1:0] addr_q;
    logic [lhbp_pkg::ADDR_W-1:0] addr_d;
    logic [lhbp_pkg::DATA_W-1:0] wdat_q;
    logic [lhbp_pkg::DATA_W-1:0] wdat_d;
    logic [lhbp_pkg::ADDR_W-1:0] addr_m_q;
    logic [lhbp_pkg::ADDR_W-1:0] addr_m_d;
    logic [lhbp_pkg::DATA_W-1:0] wdat_m_q;
    logic [lhbp_pkg::DATA_W-1:0] wdat_m_d;

    always_comb begin
        addr_d   = i_host_addr_in;
        wdat_d   = i_host_data_bus;
        addr_m_d = addr_q;
        wdat_m_d = wdat_q;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            addr_q   <= '0;
            wdat_q   <= '0;
            addr_m_q <= '0;
            wdat_m_q <= '0;
        end else begin
            addr_q   <= addr_d;
            wdat_q   <= wdat_d;
            addr_m_q <= addr_m_d;
            wdat_m_q <= wdat_m_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap capture once the synchronisers show the pin levels
    // limitation: straps must hold for two edges after release, since the
    // synchronisers sit at their reset value until then
    localparam logic [1:0] CFG_TAKE = 2'h2;
    logic [1:0]           cfg_cnt_q;
    logic [1:0]           cfg_cnt_d;
    lhbp_pkg::lhbp_mode_t mode_q;
    lhbp_pkg::lhbp_mode_t mode_d;
    logic                 big_q;
    logic                 big_d;

    always_comb begin
        cfg_cnt_d = cfg_cnt_q;
        mode_d    = mode_q;
        big_d     = big_q;
        if (cfg_cnt_q != 2'h3) begin
            cfg_cnt_d = cfg_cnt_q + 2'h1;
        end
        if (cfg_cnt_q == CFG_TAKE) begin
            if (straps_s == lhbp_pkg::STRAP_GENERIC && !bs_n_s) begin
                mode_d = lhbp_pkg::LHBP_MODE_GENERIC;
            end else if (straps_s == lhbp_pkg::STRAP_STROBE) begin
                mode_d = lhbp_pkg::LHBP_MODE_STROBE;
            end else begin
                mode_d = lhbp_pkg::LHBP_MODE_NONE;
            end
            big_d = (endian_s == lhbp_pkg::ENDIAN_BIG);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cfg_cnt_q  <= 2'h0;
            mode_q     <= lhbp_pkg::LHBP_MODE_NONE;
            big_q      <= 1'b0;
        end else begin
            cfg_cnt_q  <= cfg_cnt_d;
            mode_q     <= mode_d;
            big_q      <= big_d;
        end
    end

    assign o_mode       = mode_q;
    assign o_big_endian = big_q;

    ////////////////////////////////////////////////////////////////////////
    // decode of the current cycle
    logic       acc_act;
    logic       acc_wr;
    logic [1:0] acc_be;
    logic       rd_act;

    always_comb begin
        acc_act = 1'b0;
        acc_wr  = 1'b0;
        acc_be  = 2'h0;
        rd_act  = 1'b0;
        unique case (mode_q)
            lhbp_pkg::LHBP_MODE_GENERIC: begin
                // read enables: low byte pin and direction pin as high byte
                acc_wr  = !lwe_n_s || !hwe_n_s;
                acc_be  = acc_wr ? {!hwe_n_s, !lwe_n_s} : {!dir_s, !lrd_n_s};
                rd_act  = !cs_n_s && (!lrd_n_s || !dir_s);
                acc_act = !cs_n_s && (acc_be != 2'h0);
            end
            lhbp_pkg::LHBP_MODE_STROBE: begin
                acc_be  = {!hwe_n_s, !addr_m_q[0]};
                acc_wr  = !dir_s;
                acc_act = !cs_n_s && !bs_n_s && (acc_be != 2'h0);
                rd_act  = acc_act && dir_s;
            end
            default: begin
                acc_act = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencer, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARB  = 4'h2,
        ST_BUSY = 4'h4,
        ST_DONE = 4'h8
    } lhbp_state_t;

    lhbp_state_t state_q;
    lhbp_state_t state_d;
    lhbp_pkg::lhbp_req_t req_q;
    lhbp_pkg::lhbp_req_t req_d;
    logic [1:0] arb_cnt_q;
    logic [1:0] arb_cnt_d;
    logic wait_n_q;
    logic wait_n_d;

    always_comb begin
        state_d   = state_q;
        req_d     = req_q;
        req_d.valid = 1'b0;
        arb_cnt_d = arb_cnt_q;
        wait_n_d  = wait_n_q;
        unique case (state_q)
            ST_IDLE: begin
                wait_n_d = 1'b1;
                if (acc_act) begin
                    state_d   = ST_ARB;
                    wait_n_d  = 1'b0;
                    arb_cnt_d = 2'(lhbp_pkg::ARB_CYCLES - 1);
                    // fields come from the two-flop copies that arrive with the enables
                    req_d.write   = acc_wr;
                    req_d.byte_en = acc_be;
                    // strobe mode keeps word address, bit 0 is a strobe
                    req_d.addr    = (mode_q == lhbp_pkg::LHBP_MODE_STROBE)
                                  ? {addr_m_q[lhbp_pkg::ADDR_W-1:1], 1'b0} : addr_m_q;
                    req_d.wdata   = wdat_m_q;
                end
            end
            ST_ARB: begin
                // refresh owns the memory; host waits it out
                if (i_refresh_busy) begin
                    arb_cnt_d = 2'(lhbp_pkg::ARB_CYCLES - 1);
                end else if (arb_cnt_q != 2'h0) begin
                    arb_cnt_d = arb_cnt_q - 2'h1;
                end else begin
                    req_d.valid = 1'b1;
                    state_d     = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (i_core_done) begin
                    wait_n_d = 1'b1;
                    state_d  = ST_DONE;
                end
            end
            ST_DONE: begin
                // hold until the host ends its cycle, no double access
                if (!acc_act) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q   <= ST_IDLE;
            req_q     <= '0;
            arb_cnt_q <= 2'h0;
            wait_n_q  <= 1'b1;
        end else begin
            state_q   <= state_d;
            req_q     <= req_d;
            arb_cnt_q <= arb_cnt_d;
            wait_n_q  <= wait_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data holds until the next completion; the bus drive follows the
    // synced select and read enables through one more flop, so it lags the pins by three edges
    logic [lhbp_pkg::DATA_W-1:0] rdat_q;
    logic [lhbp_pkg::DATA_W-1:0] rdat_d;
    logic                        oe_q;
    logic                        oe_d;

    always_comb begin
        rdat_d = rdat_q;
        oe_d   = rd_act;
        if (state_q == ST_BUSY && i_core_done) begin
            rdat_d = i_core_rdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdat_q <= '0;
            oe_q   <= 1'b0;
        end else begin
            rdat_q <= rdat_d;
            oe_q   <= oe_d;
        end
    end

    // wait drops the same cycle an access is seen so host cannot slip past
    assign o_wait_n           = wait_n_q && !(state_q == ST_IDLE && acc_act);
    assign o_req              = req_q;
    assign o_host_data_bus    = rdat_q;
    assign o_host_data_bus_oe = oe_q;
endmodule : lhbp_port

// File: lhbp_port_chk.sv
// checker: pin-level timing relations of the host bus port
`timescale 1ns/10ps
module lhbp_port_chk (
    input wire logic                         i_clk,
    input wire logic                         i_reset,
    input wire logic                         i_chip_select_n,
    input wire logic [lhbp_pkg::ADDR_W-1:0]  i_host_addr_in,
    input wire logic [lhbp_pkg::DATA_W-1:0]  i_host_data_bus,
    input wire logic [lhbp_pkg::DATA_W-1:0]  o_host_data_bus,
    input wire logic                         o_host_data_bus_oe,
    input wire logic                         i_low_byte_write_n,
    input wire logic                         i_high_byte_write_n,
    input wire logic                         i_low_byte_read_n,
    input wire logic                         i_read_dir,
    input wire logic                         i_bus_start_strobe_n,
    input wire logic [lhbp_pkg::STRAP_W-1:0] i_bus_mode_straps,
    input wire logic                         i_endian_strap,
    input wire logic                         o_wait_n,
    input lhbp_pkg::lhbp_req_t               o_req,
    input wire logic                         i_refresh_busy,
    input wire logic                         i_core_done,
    input wire logic [lhbp_pkg::DATA_W-1:0]  i_core_rdata,
    input lhbp_pkg::lhbp_mode_t              o_mode,
    input wire logic                         o_big_endian
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    AST_REQ_HOLDS_WAIT: assert property (o_req.valid |-> !o_wait_n)
        else $error("core request without wait held");
    AST_WAIT_ENDS_ON_DONE: assert property (!o_wait_n && i_core_done |=> o_wait_n)
        else $error("wait not released after done");
    AST_WAIT_RISE_CAUSE: assert property ($rose(o_wait_n) |-> $past(i_core_done))
        else $error("wait released without done");
    AST_REFRESH_BLOCKS: assert property (i_refresh_busy [*3] |-> !o_req.valid)
        else $error("request issued during refresh");
    AST_STROBE_WORD_ADDR: assert property (
        o_req.valid && o_mode == lhbp_pkg::LHBP_MODE_STROBE |-> !o_req.addr[0])
        else $error("strobe mode address bit zero set");
    AST_NO_MODE_NO_REQ: assert property (
        o_mode == lhbp_pkg::LHBP_MODE_NONE |-> !o_req.valid)
        else $error("request without a valid mode");
    AST_MODE_FIXED: assert property (
        o_mode != lhbp_pkg::LHBP_MODE_NONE |=> $stable(o_mode))
        else $error("mode changed in operation");
    AST_ORDER_FIXED: assert property (
        o_mode != lhbp_pkg::LHBP_MODE_NONE && $stable(o_mode) |=> $stable(o_big_endian))
        else $error("byte order changed in operation");
    AST_OE_NEEDS_SELECT: assert property (i_chip_select_n [*5] |-> !o_host_data_bus_oe)
        else $error("data bus driven while deselected");
    AST_OE_NEEDS_READ: assert property (
        (o_mode == lhbp_pkg::LHBP_MODE_GENERIC && i_low_byte_read_n && i_read_dir) [*5]
        |-> !o_host_data_bus_oe)
        else $error("data bus driven without read");
endmodule : lhbp_port_chk
////////////////////////////////////////////////////////////////////////////////
bind lhbp_port lhbp_port_chk lhbp_port_chk_i (.*);

// File: lhbp_core_model.sv
// core model: answers port requests, refresh owned by the bench
`timescale 1ns/10ps
module lhbp_core_model (
    input wire logic            i_clk,
    input wire logic            i_reset,
    input lhbp_pkg::lhbp_req_t  i_req,
    input wire logic            i_slow,
    input wire logic            i_refresh_req,
    output logic                o_refresh_busy,
    output logic                o_core_done,
    output logic [15:0]         o_core_rdata
);
    logic [3:0]  cnt_q;
    logic [15:0] val_q;
    assign o_refresh_busy = i_refresh_req;
    assign o_core_done = (cnt_q == 4'h1);
    // outside done the data is inverted so stale reads show up
    assign o_core_rdata = o_core_done ? val_q : ~val_q;
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_q <= 4'h0;
            val_q <= 16'h0;
        end else if (i_req.valid) begin
            cnt_q <= i_slow ? 4'h6 : 4'h1;
            val_q <= i_req.addr[15:0] ^ 16'h5a5a;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule : lhbp_core_model

// File: lcd_ctrl_host_bus_port_tb.sv
// testbench: host cycles in both bus modes against the core model
`timescale 1ns/10ps
module lcd_ctrl_host_bus_port_tb;
    logic i_clk = 1'h0, i_reset = 1'h1, i_chip_select_n = 1'h1, i_endian_strap = 1'h0;
    logic i_low_byte_write_n = 1'h1, i_high_byte_write_n = 1'h1, i_low_byte_read_n = 1'h1;
    logic i_read_dir = 1'h1, i_bus_start_strobe_n = 1'h0, i_slow = 1'h0, i_refresh_req = 1'h0;
    logic [16:0] i_host_addr_in = 17'h0;
    logic [15:0] i_host_data_bus = 16'h0, o_host_data_bus, core_rdata, rd_seen;
    logic [2:0]  i_bus_mode_straps = 3'h7;
    logic        o_host_data_bus_oe, o_wait_n, o_big_endian, refresh_busy, core_done;
    logic        bs_idle, wait_seen, oe_seen;
    lhbp_pkg::lhbp_req_t  o_req, req_seen;
    lhbp_pkg::lhbp_mode_t o_mode;
    int mismatches = 0, tests_run = 0, n_req;
    always #4 i_clk = ~i_clk;
    lhbp_port lhbp_port_i (.i_clk(i_clk), .i_reset(i_reset), .i_chip_select_n(i_chip_select_n),
        .i_host_addr_in(i_host_addr_in), .i_host_data_bus(i_host_data_bus),
        .o_host_data_bus(o_host_data_bus), .o_host_data_bus_oe(o_host_data_bus_oe),
        .i_low_byte_write_n(i_low_byte_write_n), .i_high_byte_write_n(i_high_byte_write_n),
        .i_low_byte_read_n(i_low_byte_read_n), .i_read_dir(i_read_dir),
        .i_bus_start_strobe_n(i_bus_start_strobe_n), .i_bus_mode_straps(i_bus_mode_straps),
        .i_endian_strap(i_endian_strap), .o_wait_n(o_wait_n), .o_req(o_req),
        .i_refresh_busy(refresh_busy), .i_core_done(core_done), .i_core_rdata(core_rdata),
        .o_mode(o_mode), .o_big_endian(o_big_endian));
    lhbp_core_model lhbp_core_model_i (.i_clk(i_clk), .i_reset(i_reset), .i_req(o_req),
        .i_slow(i_slow), .i_refresh_req(i_refresh_req), .o_refresh_busy(refresh_busy),
        .o_core_done(core_done), .o_core_rdata(core_rdata));
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // straps are read through the synchronisers after release, so they stay put
    task automatic do_reset(input logic [2:0] s, input logic bs, input logic e);
        @(posedge i_clk);
        i_bus_mode_straps <= s;
        i_bus_start_strobe_n <= bs;
        i_endian_strap <= e;
        bs_idle <= bs;
        i_reset <= 1'h1;
        @(posedge i_clk);
        i_reset <= 1'h0;
        repeat (4) @(posedge i_clk);
    endtask : do_reset
    // ctl: write low, write high, read low, direction, start strobe
    task automatic host_cycle(input logic [16:0] a, input logic [15:0] d, input logic [4:0] ctl,
                              input logic go);
        int n;
        n = 0;
        @(posedge i_clk);
        i_chip_select_n <= 1'h0;
        i_host_addr_in <= a;
        i_host_data_bus <= d;
        {i_low_byte_write_n, i_high_byte_write_n, i_low_byte_read_n, i_read_dir,
            i_bus_start_strobe_n} <= ctl;
        do begin
            @(posedge i_clk);
            if (n == 8) i_refresh_req <= 1'h0;
            @(negedge i_clk);
            n++;
        end while (o_req.valid !== 1'h1 && n < 40);
        req_seen = o_req;
        wait_seen = o_wait_n;
        n_req = n;
        check("req", req_seen.valid, go);
        if (o_req.valid === 1'h1) begin
            n = 0;
            while (o_wait_n !== 1'h1 && n < 40) begin
                @(negedge i_clk);
                n++;
            end
            if (n == 40) begin
                mismatches++;
                test_done();
            end
            rd_seen = o_host_data_bus;
            oe_seen = o_host_data_bus_oe;
        end
        @(posedge i_clk);
        i_chip_select_n <= 1'h1;
        {i_low_byte_write_n, i_high_byte_write_n, i_low_byte_read_n, i_read_dir,
            i_bus_start_strobe_n} <= {4'hf, bs_idle};
        repeat (6) @(posedge i_clk);
    endtask : host_cycle
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(3'h7, 1'h0, 1'h0);
        check("mode", o_mode, lhbp_pkg::LHBP_MODE_GENERIC);
        check("big", o_big_endian, lhbp_pkg::ENDIAN_LITTLE);
        host_cycle(17'h12345, 16'hbeef, 5'h0e, 1'h1);
        check("wait", wait_seen, 1'h0);
        check("wr", req_seen.write, 1'h1);
        check("be", req_seen.byte_en, 2'h1);
        check("addr", req_seen.addr, 17'h12345);
        check("wdata", req_seen.wdata, 16'hbeef);
        i_refresh_req <= 1'h1;
        i_slow <= 1'h1;
        host_cycle(17'h00a11, 16'h1234, 5'h16, 1'h1);
        check("held", n_req > 8, 1'h1);
        check("be", req_seen.byte_en, 2'h2);
        host_cycle(17'h00a10, 16'h0, 5'h18, 1'h1);
        check("wr", req_seen.write, 1'h0);
        check("be", req_seen.byte_en, 2'h3);
        check("oe", oe_seen, 1'h1);
        check("rdata", rd_seen, 16'h0a10 ^ 16'h5a5a);
        do_reset(3'h3, 1'h1, 1'h1);
        check("mode", o_mode, lhbp_pkg::LHBP_MODE_STROBE);
        check("big", o_big_endian, lhbp_pkg::ENDIAN_BIG);
        host_cycle(17'h10ffe, 16'hc0de, 5'h14, 1'h1);
        check("wr", req_seen.write, 1'h1);
        check("be", req_seen.byte_en, 2'h3);
        check("addr", req_seen.addr, 17'h10ffe);
        check("wdata", req_seen.wdata, 16'hc0de);
        host_cycle(17'h00101, 16'h0, 5'h16, 1'h1);
        check("wr", req_seen.write, 1'h0);
        check("be", req_seen.byte_en, 2'h2);
        check("addr", req_seen.addr, 17'h00100);
        check("oe", oe_seen, 1'h1);
        check("rdata", rd_seen, 16'h0100 ^ 16'h5a5a);
        host_cycle(17'h00200, 16'h0, 5'h17, 1'h0);
        check("nostrobe", req_seen.valid, 1'h0);
        check("wait", wait_seen, 1'h1);
        do_reset(3'h5, 1'h0, 1'h0);
        check("mode", o_mode, lhbp_pkg::LHBP_MODE_NONE);
        host_cycle(17'h00300, 16'h0, 5'h18, 1'h0);
        check("none", req_seen.valid, 1'h0);
        check("wait", wait_seen, 1'h1);
        test_done();
    end
endmodule : lcd_ctrl_host_bus_port_tb
